// ===== src/bfsc_pkg.sv
// Package for the boot flash sum command handler: codes, sizes, carriers and states
package bfsc_pkg;

  // Mode selection bytes, echoed back as their own acknowledge
  localparam logic [7:0] MODE_UART = 8'h86;
  localparam logic [7:0] MODE_IO = 8'h30;

  // Command code and acknowledge codes for the sum query
  localparam logic [7:0] CMD_SUM = 8'h20;
  localparam logic [7:0] ACK_NACK = 8'h01; // Low nibble 1, upper nibble free
  localparam logic [7:0] ACK_ERR = 8'h08; // Low nibble 8, upper nibble free

  // Flash size in bytes and address width
  localparam int FLASH_BYTES = 524288;
  localparam int FLASH_AW = 19;

  // Reply buffer: acknowledge, sum high, sum low, check byte
  localparam int RESP_LEN = 4;
  localparam logic [1:0] RESP_ONE = 2'h0; // Last index of a one-byte reply
  localparam logic [1:0] RESP_SUM = 2'h3; // Last index of the sum reply

  // Reply FIFO shape
  localparam int TXF_WIDTH = 8;
  localparam int TXF_DEPTH = 8;

  // Received byte as handed over by the serial engine
  typedef struct packed {
    logic valid;   // One-cycle pulse, byte present
    logic err;     // Framing or overrun error on this byte
    logic baud_ok; // Baud rate derived correctly from this byte
    logic [7:0] data;
  } bfsc_rx_type;

  // Interpreter states
  typedef enum logic [2:0] {
    ST_MODE,
    ST_CMD,
    ST_SUM,
    ST_SEND,
    ST_HALT
  } bfsc_state_type;

endpackage

// ===== src/bfsc_top.sv
// Boot flash sum command interpreter with its reply FIFO
`timescale 1ns/10ps
`default_nettype none

module bfsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic do_wr, do_rd;

  // Honest flags straight from the occupancy count
  assign in_ready = (cnt_r != DEPTH_CNT);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_ptr_r];

  // Pointer and count update, wrapping at any depth
  always_comb begin
    do_wr = in_valid && in_ready;
    do_rd = out_valid && out_ready;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    cnt_nxt = cnt_r;
    if (do_wr) begin
      wr_ptr_nxt = (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
    end
    if (do_rd) begin
      rd_ptr_nxt = (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
    end
    if (do_wr && !do_rd) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (do_rd && !do_wr) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset; only the count says what is valid
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
endmodule

module bfsc_top #(
  parameter int FLASH_BYTES = bfsc_pkg::FLASH_BYTES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire bfsc_pkg::bfsc_rx_type rx,
  output logic [bfsc_pkg::FLASH_AW-1:0] flash_addr,
  input wire logic [7:0] flash_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic io_slow,
  output logic uart_mode,
  output logic aborted
);
  localparam logic [bfsc_pkg::FLASH_AW-1:0] LAST_ADDR =
    bfsc_pkg::FLASH_AW'(FLASH_BYTES - 1);

  // Check byte: two's complement of the byte sum of both halves
  function automatic logic [7:0] check_of(input logic [15:0] s);
    logic [7:0] t;
    t = s[15:8] + s[7:0];
    return 8'(~t + 8'h01);
  endfunction

  bfsc_pkg::bfsc_state_type state_r, state_nxt;
  logic [7:0] resp_r [bfsc_pkg::RESP_LEN];
  logic [7:0] resp_nxt [bfsc_pkg::RESP_LEN];
  logic [1:0] idx_r, idx_nxt, last_r, last_nxt;
  logic [15:0] sum_r, sum_nxt;
  logic [bfsc_pkg::FLASH_AW-1:0] addr_r, addr_nxt;
  logic pend_r, pend_nxt, done_r, done_nxt;
  logic uart_r, uart_nxt, slow_r, slow_nxt, abort_r, abort_nxt;
  logic push;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic tx_valid_r, tx_valid_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;

  // Command sequencing and flash summing
  always_comb begin
    state_nxt = state_r;
    resp_nxt = resp_r;
    idx_nxt = idx_r;
    last_nxt = last_r;
    sum_nxt = sum_r;
    addr_nxt = addr_r;
    pend_nxt = pend_r;
    done_nxt = done_r;
    uart_nxt = uart_r;
    slow_nxt = slow_r;
    abort_nxt = abort_r;
    push = 1'b0;
    unique case (state_r)
      bfsc_pkg::ST_MODE: begin
        if (rx.valid) begin
          last_nxt = bfsc_pkg::RESP_ONE;
          idx_nxt = '0;
          if (rx.data == bfsc_pkg::MODE_UART && rx.baud_ok && !rx.err) begin
            resp_nxt[0] = bfsc_pkg::MODE_UART;
            uart_nxt = 1'b1;
            state_nxt = bfsc_pkg::ST_SEND;
          end else if (rx.data == bfsc_pkg::MODE_IO && !rx.err) begin
            resp_nxt[0] = bfsc_pkg::MODE_IO;
            uart_nxt = 1'b0;
            state_nxt = bfsc_pkg::ST_SEND;
          end else begin
            // Bad UART baud, receive error or unknown mode: give up without a reply
            abort_nxt = 1'b1;
            state_nxt = bfsc_pkg::ST_HALT;
          end
        end
      end
      bfsc_pkg::ST_CMD: begin
        if (rx.valid) begin
          last_nxt = bfsc_pkg::RESP_ONE;
          idx_nxt = '0;
          if (rx.err) begin
            // Errors report the error code, never a refusal, in either mode
            resp_nxt[0] = bfsc_pkg::ACK_ERR;
            state_nxt = bfsc_pkg::ST_SEND;
          end else if (rx.data == bfsc_pkg::CMD_SUM) begin
            sum_nxt = '0;
            addr_nxt = '0;
            pend_nxt = 1'b0;
            done_nxt = 1'b0;
            state_nxt = bfsc_pkg::ST_SUM;
          end else begin
            resp_nxt[0] = bfsc_pkg::ACK_NACK;
            state_nxt = bfsc_pkg::ST_SEND;
          end
        end
      end
      bfsc_pkg::ST_SUM: begin
        // Flash answers one cycle after the address; pend tracks that lag
        pend_nxt = !done_r;
        if (pend_r) begin
          sum_nxt = 16'(sum_r + {8'h00, flash_data});
        end
        if (!done_r) begin
          if (addr_r == LAST_ADDR) begin
            done_nxt = 1'b1;
          end else begin
            addr_nxt = addr_r + 1'b1;
          end
        end else if (!pend_r) begin
          resp_nxt[0] = bfsc_pkg::CMD_SUM;
          resp_nxt[1] = sum_r[15:8];
          resp_nxt[2] = sum_r[7:0];
          resp_nxt[3] = check_of(sum_r);
          last_nxt = bfsc_pkg::RESP_SUM;
          idx_nxt = '0;
          state_nxt = bfsc_pkg::ST_SEND;
        end
      end
      bfsc_pkg::ST_SEND: begin
        // Stalls here while the FIFO is full
        if (fifo_in_ready) begin
          push = 1'b1;
          if (idx_r == last_r) begin
            slow_nxt = 1'b0;
            state_nxt = bfsc_pkg::ST_CMD;
          end else begin
            idx_nxt = idx_r + 1'b1;
          end
        end
      end
      bfsc_pkg::ST_HALT: begin
        state_nxt = bfsc_pkg::ST_HALT;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= bfsc_pkg::ST_MODE;
      for (int i = 0; i < bfsc_pkg::RESP_LEN; i++) begin
        resp_r[i] <= 8'h00;
      end
      idx_r <= '0;
      last_r <= '0;
      sum_r <= '0;
      addr_r <= '0;
      pend_r <= 1'b0;
      done_r <= 1'b0;
      uart_r <= 1'b0;
      slow_r <= 1'b1;
      abort_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      resp_r <= resp_nxt;
      idx_r <= idx_nxt;
      last_r <= last_nxt;
      sum_r <= sum_nxt;
      addr_r <= addr_nxt;
      pend_r <= pend_nxt;
      done_r <= done_nxt;
      uart_r <= uart_nxt;
      slow_r <= slow_nxt;
      abort_r <= abort_nxt;
    end
  end

  // Reply bytes queue here so a slow link back-pressures the sequencer
  bfsc_fifo #(
    .WIDTH(bfsc_pkg::TXF_WIDTH),
    .DEPTH(bfsc_pkg::TXF_DEPTH)
  ) u_txf (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(resp_r[idx_r]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Output stage keeps tx ports on flip-flops at the cost of one cycle
  always_comb begin
    fifo_out_ready = !tx_valid_r || tx_ready;
    tx_valid_nxt = tx_valid_r;
    tx_data_nxt = tx_data_r;
    if (fifo_out_ready) begin
      tx_valid_nxt = fifo_out_valid;
      tx_data_nxt = fifo_out_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
    end else begin
      tx_valid_r <= tx_valid_nxt;
      tx_data_r <= tx_data_nxt;
    end
  end

  assign flash_addr = addr_r;
  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;
  assign io_slow = slow_r;
  assign uart_mode = uart_r;
  assign aborted = abort_r;
endmodule

`default_nettype wire

// ===== bench/bfsc_monitor.sv
// Port checker for the boot flash sum command handler
`timescale 1ns/10ps
`default_nettype none
module bfsc_monitor #(
  parameter int FLASH_BYTES = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire bfsc_pkg::bfsc_rx_type rx,
  input wire logic [bfsc_pkg::FLASH_AW-1:0] flash_addr,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic io_slow,
  input wire logic uart_mode,
  input wire logic aborted
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // A mode byte can only be taken while the link is still slow
  logic mode_take;
  assign mode_take = rx.valid && io_slow && !aborted && !uart_mode && !rx.err;
  chk_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("reply byte moved");
  chk_uart_set: assert property (
    mode_take && rx.data == bfsc_pkg::MODE_UART && rx.baud_ok |=> uart_mode)
    else $error("uart mode not set");
  chk_bad_baud: assert property (
    mode_take && rx.data == bfsc_pkg::MODE_UART && !rx.baud_ok |=> aborted)
    else $error("bad baud not aborted");
  chk_mode_ack: assert property (
    mode_take && rx.data == bfsc_pkg::MODE_IO |-> ##[1:12] tx_valid && tx_data == 8'h30)
    else $error("io mode ack missing");
  chk_abort_quiet: assert property (aborted |-> !tx_valid)
    else $error("reply after abort");
  chk_abort_stick: assert property (aborted |=> aborted)
    else $error("abort cleared");
  chk_mode_keep: assert property (uart_mode |=> uart_mode)
    else $error("mode lost");
  chk_addr_step: assert property (
    flash_addr != 0 && flash_addr != FLASH_BYTES - 1 |=> flash_addr == $past(flash_addr) + 1)
    else $error("flash address skipped");
  chk_reset_vals: assert property (
    $fell(rst) |-> !tx_valid && io_slow && !uart_mode && !aborted) else $error("reset values");
endmodule
bind bfsc_top bfsc_monitor #(.FLASH_BYTES(FLASH_BYTES)) u_mon (.core_clk(core_clk), .rst(rst),
  .rx(rx), .flash_addr(flash_addr), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_data(tx_data), .io_slow(io_slow), .uart_mode(uart_mode), .aborted(aborted));
`default_nettype wire

// ===== bench/bfsc_host_model.sv
// Host-side partner: reply sink with stall control, plus flash array
`timescale 1ns/10ps
`default_nettype none
module bfsc_host_model (
  input wire logic core_clk,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic [bfsc_pkg::FLASH_AW-1:0] flash_addr,
  output logic [7:0] flash_data
);
  logic [7:0] got[$];
  initial tx_ready = 1'b0;
  initial flash_data = 8'h00;
  // Ready moves off the sampling edge so a stall never races the take
  always @(negedge core_clk) tx_ready = !stall;
  // A byte counts only on an edge with both valid and ready; flash reads take one cycle
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    flash_data <= flash_addr[7:0] * 8'h1D + 8'h07;
  end
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Testbench for the boot flash sum command handler
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int FB = 16;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic stall = 1'b0;
  bfsc_pkg::bfsc_rx_type rx = '0;
  logic [bfsc_pkg::FLASH_AW-1:0] flash_addr;
  logic [7:0] flash_data;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] tx_data;
  logic io_slow;
  logic uart_mode;
  logic aborted;
  int miscompares = 0;
  int num_checks = 0;
  logic [15:0] sum;
  logic [7:0] ck;
  bfsc_top #(.FLASH_BYTES(FB)) DUT (.core_clk(core_clk), .rst(rst), .rx(rx),
    .flash_addr(flash_addr), .flash_data(flash_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .io_slow(io_slow), .uart_mode(uart_mode),
    .aborted(aborted));
  bfsc_host_model host (.core_clk(core_clk), .stall(stall), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .flash_addr(flash_addr), .flash_data(flash_data));
  initial forever #20 core_clk = ~core_clk;
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    host.got.delete();
  endtask
  task automatic send(input logic [7:0] d, input logic e, input logic ok);
    @(negedge core_clk);
    rx = '{1'b1, e, ok, d};
    @(negedge core_clk);
    rx = '0;
    // Slow link until the mode byte is answered
    if (io_slow) repeat (16) @(negedge core_clk);
  endtask
  // Bounded wait so a silent design is reported, not hung on
  task automatic expect_byte(input logic [7:0] exp);
    int n;
    n = 0;
    while (host.got.size() == 0 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    if (host.got.size() == 0) host.got.push_back(~exp);
    cmp(host.got.pop_front(), exp);
  endtask
  task automatic expect_sum();
    expect_byte(bfsc_pkg::CMD_SUM);
    expect_byte(sum[15:8]);
    expect_byte(sum[7:0]);
    expect_byte(ck);
  endtask
  task automatic t_uart();
    do_reset();
    send(8'h86, 1'b0, 1'b1);
    expect_byte(8'h86);
    cmp({7'h00, uart_mode}, 8'h01);
    send(8'h20, 1'b0, 1'b1);
    expect_sum();
    send(8'h20, 1'b0, 1'b1);
    expect_sum();
    send(8'h55, 1'b0, 1'b1);
    expect_byte(bfsc_pkg::ACK_NACK);
    send(8'h20, 1'b0, 1'b1);
    expect_sum();
    send(8'h20, 1'b1, 1'b1);
    expect_byte(bfsc_pkg::ACK_ERR);
  endtask
  task automatic t_io();
    do_reset();
    send(8'h30, 1'b0, 1'b1);
    expect_byte(8'h30);
    cmp({6'h00, io_slow, uart_mode}, 8'h00);
    send(8'h20, 1'b1, 1'b1);
    expect_byte(bfsc_pkg::ACK_ERR);
    send(8'h20, 1'b0, 1'b1);
    expect_sum();
  endtask
  task automatic t_abort();
    do_reset();
    send(8'h86, 1'b0, 1'b0);
    send(8'h20, 1'b0, 1'b1);
    repeat (30) @(negedge core_clk);
    cmp({7'h00, aborted}, 8'h01);
    cmp(8'(host.got.size()), 8'h00);
  endtask
  // Two sums and a refusal pile up behind a stalled sink, then drain in order
  task automatic t_fifo();
    do_reset();
    send(8'h86, 1'b0, 1'b1);
    expect_byte(8'h86);
    stall = 1'b1;
    send(8'h20, 1'b0, 1'b1);
    repeat (FB + 12) @(negedge core_clk);
    send(8'h20, 1'b0, 1'b1);
    repeat (FB + 12) @(negedge core_clk);
    send(8'h55, 1'b0, 1'b1);
    repeat (20) @(negedge core_clk);
    cmp({7'h00, tx_valid}, 8'h01);
    stall = 1'b0;
    expect_sum();
    expect_sum();
    expect_byte(bfsc_pkg::ACK_NACK);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Expected sum from the partner's flash pattern
  initial begin
    sum = 16'h0000;
    for (int a = 0; a < FB; a++) sum += 16'(8'(a * 8'h1D + 8'h07));
    ck = 8'h00 - sum[15:8] - sum[7:0];
    t_uart();
    t_io();
    t_abort();
    t_fifo();
    summarize();
  end
  // Tests need about 400 cycles; a generous margin before calling it a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
